// ===== hw/cfr_pkg.sv
// Constants for the contact frequency reference adjust block.
// Assumes a 50 MHz APB clock and references in units of 0.1 percent.
package cfr_pkg;
  localparam int NUM_IN = 5;
  localparam int FW = 12;
  // Input function codes
  localparam logic [7:0] FN_RAMP_HOLD = 8'h0A;
  localparam logic [7:0] FN_RAISE = 8'h10;
  localparam logic [7:0] FN_LOWER = 8'h11;
  localparam logic [7:0] FN_TRIM_INC = 8'h1C;
  localparam logic [7:0] FN_TRIM_DEC = 8'h1D;
  localparam logic [7:0] FN_SAMPLE_HOLD = 8'h1E;
  // Register byte offsets
  localparam logic [7:0] OFS_SEL_FIRST = 8'h00;
  localparam logic [7:0] OFS_SEL_LAST = 8'h10;
  localparam logic [7:0] OFS_CONFIG = 8'h14;
  localparam logic [7:0] OFS_UPPER = 8'h18;
  localparam logic [7:0] OFS_LOWER = 8'h1C;
  localparam logic [7:0] OFS_MLOWER = 8'h20;
  localparam logic [7:0] OFS_TRIM = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  localparam logic [7:0] OFS_FREQ = 8'h2C;
  localparam logic [7:0] OFS_STORED = 8'h30;
  // Config and status bit positions
  localparam int CFG_RUN_SRC_LSB = 0;
  localparam int CFG_HOLD_MEM = 2;
  localparam int CFG_REF_ANALOG = 3;
  localparam int ST_ERR = 0;
  localparam int ST_MSTEP_DIS = 1;
  localparam int ST_MATCH = 2;
  localparam int ST_HELD = 3;
  // Limits and reset values, 0.1 percent units; trim step in percent
  localparam logic [FW-1:0] LIMIT_MAX = 12'h44C; // 110.0
  localparam logic [FW-1:0] UPPER_RST = 12'h3E8; // 100.0
  localparam logic [FW-1:0] LOWER_RST = 12'h000; // 0.0
  localparam logic [6:0] TRIM_MAX = 7'h64; // 100 percent
  localparam logic [6:0] TRIM_RST = 7'h0A; // 10 percent
  localparam logic [3:0] PCT_TO_TENTHS = 4'hA;
  localparam logic [1:0] RUN_SRC_RST = 2'h1;
  // Timing
  localparam int CLK_HZ = 50000000;
  localparam int SAMPLE_MS = 100;
  localparam int SAMPLE_CYC = CLK_HZ / 1000 * SAMPLE_MS;
  localparam int RAMP_TICK_US = 100;
  localparam int RAMP_TICK_CYC = CLK_HZ / 1000000 * RAMP_TICK_US;
  localparam int ADJ_TICK_MS = 10;
  localparam int ADJ_TICK_CYC = CLK_HZ / 1000 * ADJ_TICK_MS;
  typedef enum logic [1:0] {
    SH_IDLE = 2'b00,
    SH_TIME = 2'b01,
    SH_HELD = 2'b11
  } cfr_sh_e;
endpackage

// ===== hw/cfr_top.sv
// Frequency reference adjustment driven by contact inputs: raise/lower,
// trim around the analog reference and timed sample-and-hold.
// Assumes contacts and analog values synchronous to pclk; retained
// reference lives in an outside non-volatile store via nv ports.
`timescale 1ns/1ns
module cfr_top #(
  parameter int SAMPLE_CYCLES = cfr_pkg::SAMPLE_CYC,
  parameter int ADJ_CYCLES = cfr_pkg::ADJ_TICK_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [cfr_pkg::NUM_IN-1:0] contact_in,
  input wire logic run_cmd,
  input wire logic ramp_hold_in,
  input wire logic [cfr_pkg::FW-1:0] analog_ref_terminal,
  input wire logic [cfr_pkg::FW-1:0] aux_ref,
  input wire logic [cfr_pkg::FW-1:0] nv_ref_in,
  output logic [cfr_pkg::FW-1:0] nv_ref_out,
  output logic nv_save,
  output logic [cfr_pkg::FW-1:0] freq_out,
  output logic freq_match,
  output logic multistep_disable,
  output logic invalid_input_config_error
);
  localparam int FW = cfr_pkg::FW;
  localparam int N = cfr_pkg::NUM_IN;

  logic [7:0] sel_q [N];
  logic [1:0] run_source_select_q;
  logic hold_memory_enable_q;
  logic ref_from_analog_q;
  logic [FW-1:0] freq_upper_limit_pct_q;
  logic [FW-1:0] freq_lower_limit_pct_q;
  logic [FW-1:0] master_ref_lower_limit_pct_q;
  logic [6:0] trim_step_pct_q;
  logic [N-1:0] contact_q;
  logic run_q;
  logic loaded_q;
  logic [FW-1:0] ud_ref_q;
  logic [FW-1:0] stored_q;
  logic [FW-1:0] held_q;
  logic [FW-1:0] freq_q;
  logic [31:0] tick_cnt_q;
  logic [31:0] adj_cnt_q;
  logic [31:0] sh_cnt_q;
  cfr_pkg::cfr_sh_e sh_q;
  logic nv_save_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic sh_on_prev_q;

  logic [N-1:0] is_raise, is_lower, is_inc, is_dec, is_sh, is_rh;
  logic raise_on, lower_on, inc_on, dec_on, sh_on;
  logic has_ud, has_trim, has_sh, has_rh;
  logic wr_en, rd_en, addr_hit;
  logic [FW-1:0] wval;
  logic [FW-1:0] eff_lower, cfg_lower, ud_clamped, target;
  logic [FW:0] trim_sum, base_sum;
  logic [FW-1:0] step;
  logic ramp_tick, adj_tick, run_rise, run_fall, ud_edge;

  // Per-input function decode of the selectors
  generate
    for (genvar i = 0; i < N; i++) begin : g_dec
      assign is_raise[i] = (sel_q[i] == cfr_pkg::FN_RAISE);
      assign is_lower[i] = (sel_q[i] == cfr_pkg::FN_LOWER);
      assign is_inc[i] = (sel_q[i] == cfr_pkg::FN_TRIM_INC);
      assign is_dec[i] = (sel_q[i] == cfr_pkg::FN_TRIM_DEC);
      assign is_sh[i] = (sel_q[i] == cfr_pkg::FN_SAMPLE_HOLD);
      assign is_rh[i] = (sel_q[i] == cfr_pkg::FN_RAMP_HOLD);
    end
  endgenerate

  // Command levels come from the registered contacts only
  assign raise_on = |(is_raise & contact_q);
  assign lower_on = |(is_lower & contact_q);
  assign inc_on = |(is_inc & contact_q);
  assign dec_on = |(is_dec & contact_q);
  assign sh_on = |(is_sh & contact_q);
  assign has_ud = (|is_raise) & (|is_lower);
  assign has_trim = (|is_inc) & (|is_dec);
  assign has_sh = |is_sh;
  assign has_rh = |is_rh;
  assign multistep_disable = has_ud;

  // Configuration conflicts; the target is forced to zero while flagged
  assign invalid_input_config_error =
      ((|is_raise) ^ (|is_lower)) |
      (has_ud & has_rh) |
      ((|is_inc) ^ (|is_dec)) |
      (has_sh & (has_rh | has_ud | has_trim));

  // Contacts and run are sampled once; edges compare the live input with the sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      contact_q <= '0;
      run_q <= 1'b0;
    end else begin
      contact_q <= contact_in;
      run_q <= run_cmd;
    end
  end
  assign run_rise = run_cmd & ~run_q;
  assign run_fall = ~run_cmd & run_q;
  assign ud_edge = run_q & ((|(is_raise & contact_in & ~contact_q)) |
                            (|(is_lower & contact_in & ~contact_q)));

  // APB decode: zero wait states, error on unmapped offsets
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign addr_hit = (paddr[1:0] == 2'b00) &&
                    (paddr <= cfr_pkg::OFS_STORED);
  assign pready = 1'b1;
  assign wval = (pwdata[31:FW] != '0 || pwdata[FW-1:0] > cfr_pkg::LIMIT_MAX)
                ? cfr_pkg::LIMIT_MAX : pwdata[FW-1:0];

  // Writable settings; out-of-range writes saturate at the maximum
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N; i++) begin
        sel_q[i] <= 8'h00;
      end
      run_source_select_q <= cfr_pkg::RUN_SRC_RST;
      hold_memory_enable_q <= 1'b0;
      ref_from_analog_q <= 1'b1;
      freq_upper_limit_pct_q <= cfr_pkg::UPPER_RST;
      freq_lower_limit_pct_q <= cfr_pkg::LOWER_RST;
      master_ref_lower_limit_pct_q <= cfr_pkg::LOWER_RST;
      trim_step_pct_q <= cfr_pkg::TRIM_RST;
    end else if (wr_en && addr_hit) begin
      for (int i = 0; i < N; i++) begin
        if (paddr == cfr_pkg::OFS_SEL_FIRST + 8'(4 * i)) begin
          sel_q[i] <= pwdata[7:0];
        end
      end
      case (paddr)
        cfr_pkg::OFS_CONFIG: begin
          run_source_select_q <= pwdata[cfr_pkg::CFG_RUN_SRC_LSB +: 2];
          hold_memory_enable_q <= pwdata[cfr_pkg::CFG_HOLD_MEM];
          ref_from_analog_q <= pwdata[cfr_pkg::CFG_REF_ANALOG];
        end
        cfr_pkg::OFS_UPPER: freq_upper_limit_pct_q <= wval;
        cfr_pkg::OFS_LOWER: freq_lower_limit_pct_q <= wval;
        cfr_pkg::OFS_MLOWER: master_ref_lower_limit_pct_q <= wval;
        cfr_pkg::OFS_TRIM: begin
          if (pwdata[31:7] != '0 || pwdata[6:0] > cfr_pkg::TRIM_MAX) begin
            trim_step_pct_q <= cfr_pkg::TRIM_MAX;
          end else begin
            trim_step_pct_q <= pwdata[6:0];
          end
        end
        default: ;
      endcase
    end
  end

  // Read data and error response, registered at the end of the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_q <= ~addr_hit;
      prdata_q <= 32'h0000_0000;
      if (addr_hit && !pwrite) begin
        for (int i = 0; i < N; i++) begin
          if (paddr == cfr_pkg::OFS_SEL_FIRST + 8'(4 * i)) begin
            prdata_q <= {24'h00_0000, sel_q[i]};
          end
        end
        case (paddr)
          cfr_pkg::OFS_CONFIG: begin
            prdata_q[cfr_pkg::CFG_RUN_SRC_LSB +: 2] <= run_source_select_q;
            prdata_q[cfr_pkg::CFG_HOLD_MEM] <= hold_memory_enable_q;
            prdata_q[cfr_pkg::CFG_REF_ANALOG] <= ref_from_analog_q;
          end
          cfr_pkg::OFS_UPPER: prdata_q[FW-1:0] <= freq_upper_limit_pct_q;
          cfr_pkg::OFS_LOWER: prdata_q[FW-1:0] <= freq_lower_limit_pct_q;
          cfr_pkg::OFS_MLOWER:
            prdata_q[FW-1:0] <= master_ref_lower_limit_pct_q;
          cfr_pkg::OFS_TRIM: prdata_q[6:0] <= trim_step_pct_q;
          cfr_pkg::OFS_STATUS: begin
            prdata_q[cfr_pkg::ST_ERR] <= invalid_input_config_error;
            prdata_q[cfr_pkg::ST_MSTEP_DIS] <= multistep_disable;
            prdata_q[cfr_pkg::ST_MATCH] <= freq_match;
            prdata_q[cfr_pkg::ST_HELD] <= (sh_q == cfr_pkg::SH_HELD);
          end
          cfr_pkg::OFS_FREQ: prdata_q[FW-1:0] <= freq_q;
          cfr_pkg::OFS_STORED: prdata_q[FW-1:0] <= stored_q;
          default: ;
        endcase
      end
    end
  end
  assign prdata = prdata_q;
  assign pslverr = pslverr_q & psel & penable;

  // Effective lower limit: larger of analog and either configured limit
  always_comb begin
    cfg_lower = (freq_lower_limit_pct_q > master_ref_lower_limit_pct_q)
                ? freq_lower_limit_pct_q : master_ref_lower_limit_pct_q;
    eff_lower = (analog_ref_terminal > cfg_lower)
                ? analog_ref_terminal : cfg_lower;
    if (ud_ref_q > freq_upper_limit_pct_q) begin
      ud_clamped = freq_upper_limit_pct_q;
    end else if (ud_ref_q < eff_lower) begin
      ud_clamped = eff_lower;
    end else begin
      ud_clamped = ud_ref_q;
    end
  end

  // Trimmed master reference, then the auxiliary reference on top
  always_comb begin
    step = FW'(trim_step_pct_q) * FW'(cfr_pkg::PCT_TO_TENTHS);
    trim_sum = {1'b0, analog_ref_terminal};
    if (has_trim && ref_from_analog_q && analog_ref_terminal != '0) begin
      if (inc_on && !dec_on) begin
        trim_sum = {1'b0, analog_ref_terminal} + {1'b0, step};
      end else if (dec_on && !inc_on) begin
        trim_sum = (analog_ref_terminal < step) ? '0
                   : {1'b0, analog_ref_terminal} - {1'b0, step};
      end
    end
    base_sum = trim_sum + {1'b0, aux_ref};
    if (!run_cmd || invalid_input_config_error) begin
      target = '0;
    end else if (has_sh && sh_q == cfr_pkg::SH_HELD) begin
      target = held_q;
    end else if (has_ud) begin
      target = ud_clamped;
    end else if (base_sum > {1'b0, freq_upper_limit_pct_q}) begin
      target = freq_upper_limit_pct_q;
    end else begin
      target = base_sum[FW-1:0];
    end
  end

  // Free-running tick counters for ramping and raise/lower steps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= '0;
      adj_cnt_q <= '0;
    end else begin
      tick_cnt_q <= ramp_tick ? '0 : tick_cnt_q + 32'h1;
      adj_cnt_q <= adj_tick ? '0 : adj_cnt_q + 32'h1;
    end
  end
  assign ramp_tick = (tick_cnt_q == 32'(cfr_pkg::RAMP_TICK_CYC - 1));
  assign adj_tick = (adj_cnt_q == 32'(ADJ_CYCLES - 1));

  // Raise/lower reference; start value depends on hold memory
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ud_ref_q <= '0;
    end else if (run_rise) begin
      ud_ref_q <= hold_memory_enable_q ? stored_q : '0;
    end else if (run_q && adj_tick) begin
      if (raise_on && !lower_on) begin
        ud_ref_q <= ud_clamped + FW'(1);
      end else if (lower_on && !raise_on && ud_clamped != '0) begin
        ud_ref_q <= ud_clamped - FW'(1);
      end else begin
        ud_ref_q <= ud_clamped;
      end
    end
  end

  // Retained reference: loaded once after reset, saved at stop.
  // A stop beats a clearing edge in the same cycle: run has already ended.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stored_q <= '0;
      loaded_q <= 1'b0;
      nv_save_q <= 1'b0;
    end else begin
      loaded_q <= 1'b1;
      nv_save_q <= 1'b0;
      if (!loaded_q) begin
        stored_q <= nv_ref_in;
      end else if (has_ud && hold_memory_enable_q && run_fall) begin
        stored_q <= ud_clamped;
        nv_save_q <= 1'b1;
      end else if (has_ud && ud_edge) begin
        stored_q <= '0;
        nv_save_q <= 1'b1;
      end
    end
  end
  assign nv_ref_out = stored_q;
  assign nv_save = nv_save_q;

  // Sample-hold timer; held value is volatile and cleared by reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_q <= cfr_pkg::SH_IDLE;
      sh_cnt_q <= '0;
      held_q <= '0;
    end else begin
      case (sh_q)
        cfr_pkg::SH_IDLE: begin
          sh_cnt_q <= '0;
          if (sh_on && has_sh) begin
            sh_q <= cfr_pkg::SH_TIME;
          end
        end
        cfr_pkg::SH_TIME: begin
          sh_cnt_q <= sh_cnt_q + 32'h1;
          if (!sh_on) begin
            sh_q <= cfr_pkg::SH_IDLE;
          end else if (sh_cnt_q == 32'(SAMPLE_CYCLES - 1)) begin
            held_q <= analog_ref_terminal;
            sh_q <= cfr_pkg::SH_HELD;
          end
        end
        cfr_pkg::SH_HELD: begin
          // Held value stays in use until a new on-edge restarts timing or no input selects sample-hold
          if (!has_sh) begin
            sh_q <= cfr_pkg::SH_IDLE;
          end else if (sh_on && !sh_on_prev_q) begin
            sh_q <= cfr_pkg::SH_TIME;
            sh_cnt_q <= '0;
          end
        end
        default: sh_q <= cfr_pkg::SH_IDLE;
      endcase
    end
  end

  // Previous sample-hold level, for the restart edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_on_prev_q <= 1'b0;
    end else begin
      sh_on_prev_q <= sh_on;
    end
  end

  // Output ramp: one 0.1 percent step per ramp tick toward target
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_q <= '0;
    end else if (ramp_tick) begin
      if (freq_q < target) begin
        freq_q <= freq_q + FW'(1);
      end else if (freq_q > target) begin
        freq_q <= freq_q - FW'(1);
      end
    end
  end
  assign freq_out = freq_q;
  assign freq_match = run_cmd & (freq_q == target);
endmodule

// ===== test/cfr_chk_chk.sv
// Port checker for the frequency reference adjust block.
// Assumes selectors change only through APB writes.
`timescale 1ns/1ns
module cfr_chk #(
  parameter int SAMPLE_CYCLES = 20,
  parameter int ADJ_CYCLES = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic run_cmd,
  input wire logic [11:0] freq_out,
  input wire logic freq_match,
  input wire logic multistep_disable,
  input wire logic invalid_input_config_error,
  input wire logic nv_save
);
  logic [7:0] sel_q [cfr_pkg::NUM_IN];
  logic up, dn, ti, td, sh, rh, err_exp;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow selectors so the config checks need no internal probes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < cfr_pkg::NUM_IN; i++) begin
        sel_q[i] <= 8'h00;
      end
    end else if (psel && penable && pready && pwrite &&
                 paddr[1:0] == 2'h0 && paddr <= cfr_pkg::OFS_SEL_LAST) begin
      sel_q[paddr[4:2]] <= pwdata[7:0];
    end
  end
  // Which functions are assigned on any input
  always_comb begin
    {up, dn, ti, td, sh, rh} = 6'h00;
    for (int i = 0; i < cfr_pkg::NUM_IN; i++) begin
      up = up | (sel_q[i] == cfr_pkg::FN_RAISE);
      dn = dn | (sel_q[i] == cfr_pkg::FN_LOWER);
      ti = ti | (sel_q[i] == cfr_pkg::FN_TRIM_INC);
      td = td | (sel_q[i] == cfr_pkg::FN_TRIM_DEC);
      sh = sh | (sel_q[i] == cfr_pkg::FN_SAMPLE_HOLD);
      rh = rh | (sel_q[i] == cfr_pkg::FN_RAMP_HOLD);
    end
    err_exp = (up ^ dn) | (ti ^ td) | ((up | dn) & rh) |
              (sh & (rh | up | dn | ti | td));
  end
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable;
  endsequence
  sequence ramp_rest_s;
    $stable(freq_out) [*8];
  endsequence
  ready_in_access_a: assert property (access_s |-> pready)
    else $error("pready low in access phase");
  err_phase_a: assert property (pslverr |-> access_s)
    else $error("pslverr outside access phase");
  unmapped_err_a: assert property (
    setup_s ##0 (paddr > cfr_pkg::OFS_STORED) |=> pslverr)
    else $error("unmapped access without pslverr");
  config_error_a: assert property (
    invalid_input_config_error == err_exp)
    else $error("config error flag wrong");
  multistep_off_a: assert property (
    multistep_disable == (up && dn))
    else $error("multistep disable wrong");
  match_needs_run_a: assert property (!run_cmd |-> !freq_match)
    else $error("match without run");
  ramp_step_a: assert property ($changed(freq_out) |->
    (freq_out == $past(freq_out) + 12'h001) ||
    (freq_out + 12'h001 == $past(freq_out)))
    else $error("frequency jumped");
  ramp_pace_a: assert property ($changed(freq_out) |=> ramp_rest_s)
    else $error("frequency ramps too fast");
  save_pulse_a: assert property (nv_save |=> !nv_save)
    else $error("save pulse too long");
endmodule
bind cfr_top cfr_chk #(
  .SAMPLE_CYCLES(SAMPLE_CYCLES),
  .ADJ_CYCLES(ADJ_CYCLES)
) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .run_cmd(run_cmd), .freq_out(freq_out),
  .freq_match(freq_match), .multistep_disable(multistep_disable),
  .invalid_input_config_error(invalid_input_config_error),
  .nv_save(nv_save)
);

// ===== test/cfr_far.sv
// Far side model: contact switches, analog sources and retained store.
// Assumes the bench changes levels just after a rising pclk edge.
`timescale 1ns/1ns
module cfr_far #(
  parameter logic [11:0] NV_INIT = 12'h005 // Arbitrary start value
) (
  input wire logic pclk,
  input wire logic [4:0] sw_lvl,
  input wire logic [11:0] ana_lvl,
  input wire logic [11:0] aux_lvl,
  input wire logic [11:0] nv_ref_out,
  input wire logic nv_save,
  output logic [4:0] contact_in,
  output logic [11:0] analog_ref_terminal,
  output logic [11:0] aux_ref,
  output logic [11:0] nv_ref_in
);
  logic [11:0] store_q = NV_INIT;
  // Switches follow the bench; run is driven by the bench directly
  assign contact_in = sw_lvl;
  assign analog_ref_terminal = ana_lvl;
  assign aux_ref = aux_lvl;
  assign nv_ref_in = store_q;
  // No reset here, so the store outlives a power cycle
  always @(posedge pclk) begin
    if (nv_save) begin
      store_q <= nv_ref_out;
    end
  end
endmodule

// ===== test/tb.sv
// Self-checking bench for the frequency reference adjust block.
// Assumes the far side model and the bound checker are compiled first.
`timescale 1ns/1ns
module tb;
  localparam logic [11:0] NV_INIT = 12'h005; // Arbitrary value
  localparam int LIMIT = 100000;
  // Table entries: {multistep-disable, error, sel5 .. sel1}
  localparam logic [41:0] TBL [11] = '{42'h1_0000000010,
    42'h2_0000001110, 42'h3_00000A1110, 42'h1_000000001C,
    42'h0_0000001D1C, 42'h0_000000001E, 42'h3_000011101E,
    42'h1_00001D1C1E, 42'h1_0000000A1E, 42'h1_0000000011,
    42'h1_000000001D};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run_cmd = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, nv_save, freq_match, ms_dis, cfg_err;
  logic [4:0] sw_lvl = 5'h00, contact_in;
  logic [11:0] ana_lvl = 12'h000, aux_lvl = 12'h000;
  logic [11:0] ana, aux, nv_in, nv_out, freq_out;
  logic [32:0] exp_q [$];
  logic [31:0] rnd = 32'h77705B3D;
  int errors = 0, cmp_count = 0, cycles = 0;
  always #10 pclk = ~pclk;
  cfr_top #(.SAMPLE_CYCLES(20), .ADJ_CYCLES(8)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .contact_in(contact_in),
    .run_cmd(run_cmd), .ramp_hold_in(1'b0),
    .analog_ref_terminal(ana), .aux_ref(aux), .nv_ref_in(nv_in),
    .nv_ref_out(nv_out), .nv_save(nv_save), .freq_out(freq_out),
    .freq_match(freq_match), .multistep_disable(ms_dis),
    .invalid_input_config_error(cfg_err));
  cfr_far #(.NV_INIT(NV_INIT)) far (.pclk(pclk), .sw_lvl(sw_lvl),
    .ana_lvl(ana_lvl), .aux_lvl(aux_lvl), .nv_ref_out(nv_out),
    .nv_save(nv_save), .contact_in(contact_in),
    .analog_ref_terminal(ana), .aux_ref(aux), .nv_ref_in(nv_in));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string nm, input logic [32:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // One APB transfer; an idle edge first keeps strobes single-driven
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // Expected {pslverr, prdata} is noted before the read goes out
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic see_match(input logic e);
    repeat (4) @(posedge pclk);
    check("freq_match", {32'h0, freq_match}, {32'h0, e});
  endtask
  // Bounded wait: the ramp moves one step per tick
  task automatic wait_match(input int n);
    for (int k = 0; k < n && freq_match !== 1'b1; k++) begin
      @(posedge pclk);
    end
  endtask
  task automatic pulse(input int n);
    sw_lvl <= 5'h01;
    repeat (n) @(posedge pclk);
    sw_lvl <= 5'h00;
  endtask
  task automatic power();
    run_cmd <= 1'b0;
    sw_lvl <= 5'h00;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  // Read monitor takes the oldest note per completed read
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      check("prdata", {pslverr, prdata}, exp_q.pop_front());
    end
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      conclude();
    end
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, clamps and an unmapped place
    rd(cfr_pkg::OFS_CONFIG, 33'h9);
    rd(cfr_pkg::OFS_UPPER, 33'h3E8);
    rd(cfr_pkg::OFS_LOWER, 33'h0);
    rd(cfr_pkg::OFS_TRIM, 33'h0A);
    rd(cfr_pkg::OFS_STORED, {21'h0, NV_INIT});
    rd(8'h34, 33'h100000000);
    wr(cfr_pkg::OFS_UPPER, 32'hFFF);
    rd(cfr_pkg::OFS_UPPER, 33'h44C);
    wr(cfr_pkg::OFS_TRIM, 32'hC8);
    rd(cfr_pkg::OFS_TRIM, 33'h64);
    wr(cfr_pkg::OFS_UPPER, 32'h3E8);
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      wr(cfr_pkg::OFS_MLOWER, {20'h0, rnd[11:0]});
      rd(cfr_pkg::OFS_MLOWER, (rnd[11:0] > 12'h44C) ? 33'h44C :
         {21'h0, rnd[11:0]});
    end
    // Every adjust code alone except ramp hold, in the two valid pairs and in conflicting mixes
    for (int i = 0; i < 11; i++) begin
      for (int j = 0; j < 5; j++) begin
        wr(8'(4 * j), {24'h0, TBL[i][8*j +: 8]});
      end
      rd(cfr_pkg::OFS_STATUS,
         {31'h0, TBL[i][41:40]});
    end
    // Trim around the analog reference, step of one percent
    power();
    wr(cfr_pkg::OFS_SEL_FIRST, 32'h1C);
    wr(8'h04, 32'h1D);
    wr(cfr_pkg::OFS_TRIM, 32'h01);
    ana_lvl <= 12'h003;
    sw_lvl <= 5'h02;
    run_cmd <= 1'b1;
    see_match(1'b1);
    aux_lvl <= 12'h002;
    see_match(1'b0);
    aux_lvl <= 12'h000;
    sw_lvl <= 5'h03;
    see_match(1'b0);
    wait_match(20000);
    rd(cfr_pkg::OFS_FREQ, 33'h003);
    sw_lvl <= 5'h01;
    see_match(1'b0);
    wr(cfr_pkg::OFS_TRIM, 32'h00);
    see_match(1'b1);
    // Reference not from analog: trim must stay out of the sum
    wr(cfr_pkg::OFS_TRIM, 32'h01);
    wr(cfr_pkg::OFS_CONFIG, 32'h01);
    see_match(1'b1);
    // Sample and hold: short press ignored, long press captures
    power();
    wr(cfr_pkg::OFS_SEL_FIRST, 32'h1E);
    ana_lvl <= 12'h002;
    run_cmd <= 1'b1;
    pulse(10);
    rd(cfr_pkg::OFS_STATUS, 33'h0);
    pulse(30);
    ana_lvl <= 12'h007;
    rd(cfr_pkg::OFS_STATUS, 33'h8);
    wait_match(12000);
    rd(cfr_pkg::OFS_FREQ, 33'h002);
    power();
    rd(cfr_pkg::OFS_STATUS, 33'h0);
    // Raise and lower with a lower limit above the analog value
    wr(cfr_pkg::OFS_SEL_FIRST, 32'h10);
    wr(8'h04, 32'h11);
    wr(cfr_pkg::OFS_LOWER, 32'h004);
    ana_lvl <= 12'h001;
    check("multistep", {32'h0, ms_dis}, 33'h1);
    run_cmd <= 1'b1;
    wait_match(25000);
    rd(cfr_pkg::OFS_FREQ, 33'h004);
    // Hold memory: a stop saves, a run after power goes to the store
    wr(cfr_pkg::OFS_CONFIG, 32'h0D);
    run_cmd <= 1'b0;
    repeat (3) @(posedge pclk);
    power();
    rd(cfr_pkg::OFS_STORED, 33'h004);
    wr(cfr_pkg::OFS_SEL_FIRST, 32'h10);
    wr(8'h04, 32'h11);
    wr(cfr_pkg::OFS_CONFIG, 32'h0D);
    run_cmd <= 1'b1;
    wait_match(25000);
    rd(cfr_pkg::OFS_FREQ, 33'h004);
    pulse(4);
    rd(cfr_pkg::OFS_STORED, 33'h0);
    // Memory off so the stop saves nothing; the cleared store survives
    wr(cfr_pkg::OFS_CONFIG, 32'h09);
    power();
    rd(cfr_pkg::OFS_STORED, 33'h0);
    conclude();
  end
endmodule
